// File: eas_consts.svh
`ifndef EAS_CONSTS_SVH
`define EAS_CONSTS_SVH

// ==========================================================
// register addresses (7-bit serial address field)
`define EAS_ADDR_NOOP_LO   7'h00
`define EAS_ADDR_STATUS    7'h01
`define EAS_ADDR_INT_EN    7'h02
`define EAS_ADDR_INT_EN2   7'h03
`define EAS_ADDR_NOOP_HI   7'h7F

// ==========================================================
// status field positions
`define EAS_BIT_THR        23
`define EAS_BIT_OVF        22
`define EAS_BIT_FAST       21
`define EAS_BIT_DCL        20
`define EAS_BIT_PLL        8

// ==========================================================
// reset values
`define EAS_INT_EN_RST     24'h00_0000

// ==========================================================
// frame layout and timing
`define EAS_CMD_LAST_BIT   6'h07
`define EAS_FRAME_LAST_BIT 6'h1F
`define EAS_CLK_HZ         64'd25000000
`define EAS_LOFF_TIME_MS   64'd115

`endif

// File: eas_pkg.sv
package eas_pkg;

   // ==========================================================
   // frame phases
   typedef enum logic [1:0]
   {
      EAS_IDLE = 2'b00,
      EAS_CMD  = 2'b01,
      EAS_DATA = 2'b10,
      EAS_DONE = 2'b11
   } eas_phase_e;

   typedef logic [23:0] eas_word_t;

endpackage : eas_pkg

// File: eas_status_regs.sv
`timescale 1ns/1ps
`include "eas_consts.svh"

module eas_status_regs
   import eas_pkg::*;
#(
   parameter int unsigned LOFF_CYCLES =
      32'((`EAS_LOFF_TIME_MS * `EAS_CLK_HZ) / 64'd1000),
   parameter int          CNT_W       = 22
)
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       sclk,
   input  wire logic       csb_n,
   input  wire logic       sdi,
   output logic            sdo,
   output logic            sdo_oe,
   output logic            int_n,
   input  wire logic       fifo_at_threshold,
   input  wire logic       fifo_overflow_evt,
   input  wire logic       fifo_reset_cmd,
   input  wire logic       synchronize_command,
   input  wire logic       fast_recovery_active,
   input  wire logic       fast_recovery_clear_mode,
   input  wire logic [3:0] leads_off_cond,
   input  wire logic       pll_powered,
   input  wire logic       pll_locked
);

   // ==========================================================
   // pin synchronisers
   logic       sclk_s1, sclk_s2, sclk_s3;
   logic       csb_s1, csb_s2;
   logic       sdi_s1, sdi_s2;
   logic       sclk_rise, sclk_fall;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         csb_s1  <= 1'b1;
         csb_s2  <= 1'b1;
         sdi_s1  <= 1'b0;
         sdi_s2  <= 1'b0;
      end
      else
      begin
         sclk_s1 <= sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         csb_s1  <= csb_n;
         csb_s2  <= csb_s1;
         sdi_s1  <= sdi;
         sdi_s2  <= sdi_s1;
      end
   end

   assign sclk_rise = sclk_s2 & ~sclk_s3 & ~csb_s2;
   assign sclk_fall = ~sclk_s2 & sclk_s3 & ~csb_s2;

   // ==========================================================
   // frame decode
   eas_phase_e phase_q;
   logic [5:0] bit_cnt_q;
   logic [6:0] shift_q;
   logic [22:0] wdata_q;
   logic [6:0] addr_q;
   logic       rd_q;
   logic       frame_end;
   logic       status_rd_done;
   logic       en_wr;

   always_ff @(posedge clock)
   begin
      if (rst || csb_s2)
      begin
         phase_q   <= EAS_IDLE;
         bit_cnt_q <= 6'h00;
         shift_q   <= 7'h00;
         wdata_q   <= 23'h00_0000;
         addr_q    <= 7'h00;
         rd_q      <= 1'b0;
      end
      else if (sclk_rise)
      begin
         bit_cnt_q <= bit_cnt_q + 6'h01;
         unique case (phase_q)
            EAS_IDLE,
            EAS_CMD:
            begin
               shift_q <= {shift_q[5:0], sdi_s2};
               if (bit_cnt_q == `EAS_CMD_LAST_BIT)
               begin
                  addr_q  <= shift_q;
                  rd_q    <= sdi_s2;
                  phase_q <= EAS_DATA;
               end
               else
               begin
                  phase_q <= EAS_CMD;
               end
            end
            EAS_DATA:
            begin
               wdata_q <= {wdata_q[21:0], sdi_s2};
               if (bit_cnt_q == `EAS_FRAME_LAST_BIT)
               begin
                  phase_q <= EAS_DONE;
               end
            end
            EAS_DONE:
            begin
               // bits past the 32nd are ignored until select rises
               phase_q <= EAS_DONE;
            end
         endcase
      end
   end

   assign frame_end      = sclk_rise && (phase_q == EAS_DATA)
                           && (bit_cnt_q == `EAS_FRAME_LAST_BIT);
   assign status_rd_done = frame_end && rd_q && (addr_q == `EAS_ADDR_STATUS);
   // only the enable register takes writes; no_operation_high and status writes fall away
   assign en_wr          = frame_end && !rd_q && (addr_q == `EAS_ADDR_INT_EN);

   // ==========================================================
   // status terms
   logic            thr_q, ovf_q, fast_q, dcl_q, pll_q;
   logic [3:0]      detail_q;
   logic [CNT_W-1:0] loff_cnt_q;
   logic            loff_hit;
   logic [3:0]      detail_set;
   eas_word_t       status_w;

   always_ff @(posedge clock)
   begin
      thr_q <= ~rst & fifo_at_threshold;
   end

   always_ff @(posedge clock)
   begin
      ovf_q <= ~rst & (fifo_overflow_evt
                       | (ovf_q & ~(fifo_reset_cmd | synchronize_command)));
   end

   // clear mode one tracks the engine live, mode zero holds until read
   always_ff @(posedge clock)
   begin
      fast_q <= ~rst & (fast_recovery_active
                        | (fast_q & ~(fast_recovery_clear_mode | status_rd_done)));
   end

   // saturating persistence timer; any gap restarts it
   always_ff @(posedge clock)
   begin
      if (rst || (leads_off_cond == 4'h0))
      begin
         loff_cnt_q <= '0;
      end
      else if (loff_cnt_q < CNT_W'(LOFF_CYCLES))
      begin
         loff_cnt_q <= loff_cnt_q + CNT_W'(1);
      end
   end

   assign loff_hit   = (leads_off_cond != 4'h0)
                       && (loff_cnt_q >= CNT_W'(LOFF_CYCLES));
   assign detail_set = loff_hit ? leads_off_cond : 4'h0;

   // set wins over the clear from a completing status read
   always_ff @(posedge clock)
   begin
      dcl_q    <= ~rst & (loff_hit | (dcl_q & ~status_rd_done));
      detail_q <= {4{~rst}} & (detail_set | (detail_q & {4{~status_rd_done}}));
   end

   always_ff @(posedge clock)
   begin
      pll_q <= ~rst & ((pll_powered & ~pll_locked) | (pll_q & ~status_rd_done));
   end

   // unnamed positions tie to zero
   always_comb
   begin
      status_w                = 24'h00_0000;
      status_w[`EAS_BIT_THR]  = thr_q;
      status_w[`EAS_BIT_OVF]  = ovf_q;
      status_w[`EAS_BIT_FAST] = fast_q;
      status_w[`EAS_BIT_DCL]  = dcl_q;
      status_w[`EAS_BIT_PLL]  = pll_q;
      status_w[3:0]           = detail_q;
   end

   // ==========================================================
   // enable register and interrupt
   eas_word_t en_q;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         en_q <= `EAS_INT_EN_RST;
      end
      else if (en_wr)
      begin
         en_q <= {wdata_q, sdi_s2};
      end
   end

   always_ff @(posedge clock)
   begin
      // reset forces the idle high level
      int_n <= rst | ~|(status_w[23:8] & en_q[23:8]);
   end

   // ==========================================================
   // read data path
   function automatic eas_word_t read_mux(input logic [6:0] a,
                                          input eas_word_t st,
                                          input eas_word_t en);
      eas_word_t r;
      r = 24'h00_0000;
      if (a == `EAS_ADDR_STATUS)
      begin
         r = st;
      end
      else if (a == `EAS_ADDR_INT_EN)
      begin
         r = en;
      end
      // no_operation_high and unmapped addresses keep the zero word
      return r;
   endfunction : read_mux

   eas_word_t tx_q;
   logic      load_tx;

   assign load_tx = sclk_rise && (phase_q != EAS_DATA) && (phase_q != EAS_DONE)
                    && (bit_cnt_q == `EAS_CMD_LAST_BIT) && sdi_s2;

   // snapshot taken at the command edge so one frame reads a stable word
   always_ff @(posedge clock)
   begin
      if (rst || csb_s2)
      begin
         tx_q <= 24'h00_0000;
         sdo  <= 1'b0;
      end
      else if (load_tx)
      begin
         tx_q <= read_mux(shift_q, status_w, en_q);
      end
      else if (sclk_fall && (phase_q == EAS_DATA))
      begin
         sdo  <= tx_q[23];
         tx_q <= {tx_q[22:0], 1'b0};
      end
   end

   always_ff @(posedge clock)
   begin
      sdo_oe <= ~rst & ~csb_s2;
   end

   // ==========================================================
   // checks
   noop_read_zero_a : assert property (@(posedge clock) disable iff (rst)
      (phase_q == EAS_DATA && rd_q
       && (addr_q == `EAS_ADDR_NOOP_LO || addr_q == `EAS_ADDR_NOOP_HI)) |-> (sdo == 1'b0))
      else $error("no_operation_high read drove a one");

   noop_write_hold_a : assert property (@(posedge clock) disable iff (rst)
      (frame_end && !rd_q && addr_q != `EAS_ADDR_INT_EN) |=> $stable(en_q))
      else $error("write to other address changed enables");

   status_mask_free_a : assert property (@(posedge clock) disable iff (rst)
      (load_tx && shift_q == `EAS_ADDR_STATUS) |=> (tx_q == $past(status_w)))
      else $error("status snapshot differs from live terms");

   thr_follow_a : assert property (@(posedge clock) disable iff (rst)
      ##1 (thr_q == $past(fifo_at_threshold)))
      else $error("threshold flag lags its condition");

   ovf_hold_a : assert property (@(posedge clock) disable iff (rst)
      (ovf_q && !fifo_reset_cmd && !synchronize_command) |=> ovf_q)
      else $error("overflow dropped without reset or sync");

   fast_set_a : assert property (@(posedge clock) disable iff (rst)
      fast_recovery_active |=> fast_q)
      else $error("fast recovery flag missed engagement");

   loff_late_a : assert property (@(posedge clock) disable iff (rst)
      ($rose(dcl_q)) |-> (loff_cnt_q >= CNT_W'(LOFF_CYCLES)) || $past(loff_hit))
      else $error("leads-off flag before persistence time");

   loff_latch_a : assert property (@(posedge clock) disable iff (rst)
      (dcl_q && !status_rd_done) |=> dcl_q)
      else $error("leads-off flag cleared without status read");

   detail_with_dcl_a : assert property (@(posedge clock) disable iff (rst)
      (detail_q != 4'h0) |-> dcl_q)
      else $error("detail bits without leads-off flag");

   pll_set_a : assert property (@(posedge clock) disable iff (rst)
      (pll_powered && !pll_locked) |=> pll_q)
      else $error("pll flag missing while unlocked");

   int_or_a : assert property (@(posedge clock) disable iff (rst)
      ##1 (int_n == !(|($past(status_w[23:8]) & $past(en_q[23:8])))))
      else $error("interrupt output wrong for enabled terms");

endmodule : eas_status_regs

// File: eas_host_model.sv
`timescale 1ns/1ps
module eas_host_model
   import eas_pkg::*;
(
   input  wire logic clock,
   input  wire logic sdo,
   output logic      sclk,
   output logic      csb_n,
   output logic      sdi
);
   // ==========
   // spi mode 0 host, 8 system clocks per sclk period
   initial
   begin
      sclk  = 1'b0;
      csb_n = 1'b1;
      sdi   = 1'b0;
   end

   // n below 32 makes a short frame that must be dropped
   task automatic xfer(input logic [6:0] a, input logic rd, input eas_word_t wd,
                       input int n, output eas_word_t q);
      logic [31:0] w;
      w = {a, rd, wd};
      q = 24'h00_0000;
      @(negedge clock);
      csb_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         sdi = w[31-i];
         repeat (4) @(negedge clock);
         sclk = 1'b1;
         if (i > 7)
            q = {q[22:0], sdo};
         repeat (4) @(negedge clock);
         sclk = 1'b0;
      end
      // all n rises seen before release, so a full status read clears the held fast, leads-off and pll flags
      repeat (4) @(negedge clock);
      csb_n = 1'b1;
      // released line must not keep its last value
      sdi = ~sdi;
      repeat (4) @(negedge clock);
   endtask : xfer
endmodule : eas_host_model

// File: eas_status_regs_test.sv
`timescale 1ns/1ps
`include "eas_consts.svh"
module eas_status_regs_test
   import eas_pkg::*;
;
   logic       clock, rst, sclk, csb_n, sdi, sdo, sdo_oe, int_n;
   logic       thr, ovf, frst, sync, fast, fmode, pwr, lock;
   logic [3:0] loff;
   int         bad_count, compares;
   eas_word_t  q;

   initial clock = 1'b0;
   always #20 clock = ~clock;

   // ==========
   // short leads-off count keeps the run brief
   eas_status_regs #(.LOFF_CYCLES(20)) dut_u (
      .clock(clock), .rst(rst), .sclk(sclk), .csb_n(csb_n), .sdi(sdi),
      .sdo(sdo), .sdo_oe(sdo_oe), .int_n(int_n), .fifo_at_threshold(thr),
      .fifo_overflow_evt(ovf), .fifo_reset_cmd(frst), .synchronize_command(sync),
      .fast_recovery_active(fast), .fast_recovery_clear_mode(fmode),
      .leads_off_cond(loff), .pll_powered(pwr), .pll_locked(lock));

   eas_host_model host_u (.clock(clock), .sdo(sdo), .sclk(sclk), .csb_n(csb_n),
                          .sdi(sdi));

   // ==========
   task automatic chk(input eas_word_t got, input eas_word_t exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic rd(input logic [6:0] a, input eas_word_t exp);
      host_u.xfer(a, 1'b1, 24'h00_0000, 32, q);
      chk(q, exp);
   endtask : rd

   task automatic wr(input logic [6:0] a, input eas_word_t d);
      host_u.xfer(a, 1'b0, d, 32, q);
   endtask : wr

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask : cyc

   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test

   // ==========
   task automatic t_reset();
      fork
         rd(`EAS_ADDR_STATUS, 24'h00_0000);
         begin
            cyc(40);
            chk({23'h00_0000, sdo_oe}, 24'h00_0001);
         end
      join
      chk({23'h00_0000, sdo_oe}, 24'h00_0000);
      rd(`EAS_ADDR_INT_EN, 24'h00_0000);
      chk({23'h00_0000, int_n}, 24'h00_0001);
      $display("test reset done");
   endtask : t_reset

   task automatic t_noop();
      thr = 1'b1;
      wr(`EAS_ADDR_NOOP_LO, 24'hFF_FFFF);
      wr(`EAS_ADDR_NOOP_HI, 24'hFF_FFFF);
      wr(`EAS_ADDR_STATUS, 24'h00_0000);
      rd(`EAS_ADDR_NOOP_LO, 24'h00_0000);
      rd(`EAS_ADDR_NOOP_HI, 24'h00_0000);
      rd(`EAS_ADDR_INT_EN, 24'h00_0000);
      rd(`EAS_ADDR_STATUS, 24'h80_0000);
      chk({23'h00_0000, int_n}, 24'h00_0001);
      $display("test noop done");
   endtask : t_noop

   task automatic t_int();
      wr(`EAS_ADDR_INT_EN, 24'h80_0000);
      cyc(2);
      chk({23'h00_0000, int_n}, 24'h00_0000);
      host_u.xfer(`EAS_ADDR_INT_EN, 1'b0, 24'h00_0000, 20, q);
      rd(`EAS_ADDR_INT_EN, 24'h80_0000);
      thr = 1'b0;
      cyc(3);
      chk({23'h00_0000, int_n}, 24'h00_0001);
      rd(`EAS_ADDR_STATUS, 24'h00_0000);
      wr(`EAS_ADDR_INT_EN, 24'h00_0000);
      $display("test int done");
   endtask : t_int

   task automatic t_ovf();
      ovf = 1'b1;
      cyc(1);
      ovf = 1'b0;
      rd(`EAS_ADDR_STATUS, 24'h40_0000);
      rd(`EAS_ADDR_STATUS, 24'h40_0000);
      frst = 1'b1;
      cyc(1);
      frst = 1'b0;
      rd(`EAS_ADDR_STATUS, 24'h00_0000);
      ovf = 1'b1;
      cyc(1);
      ovf = 1'b0;
      sync = 1'b1;
      cyc(1);
      sync = 1'b0;
      rd(`EAS_ADDR_STATUS, 24'h00_0000);
      $display("test ovf done");
   endtask : t_ovf

   task automatic t_fast();
      fast = 1'b1;
      cyc(2);
      fast = 1'b0;
      rd(`EAS_ADDR_STATUS, 24'h20_0000);
      rd(`EAS_ADDR_STATUS, 24'h00_0000);
      fmode = 1'b1;
      fast = 1'b1;
      cyc(2);
      fast = 1'b0;
      rd(`EAS_ADDR_STATUS, 24'h00_0000);
      fast = 1'b1;
      rd(`EAS_ADDR_STATUS, 24'h20_0000);
      fast = 1'b0;
      $display("test fast done");
   endtask : t_fast

   task automatic t_loff();
      // held for exactly the persistence count, one cycle short of setting the flag
      loff = 4'hA;
      cyc(20);
      loff = 4'h0;
      rd(`EAS_ADDR_STATUS, 24'h00_0000);
      loff = 4'h5;
      cyc(22);
      rd(`EAS_ADDR_STATUS, 24'h10_0005);
      loff = 4'h0;
      rd(`EAS_ADDR_STATUS, 24'h10_0005);
      rd(`EAS_ADDR_STATUS, 24'h00_0000);
      $display("test loff done");
   endtask : t_loff

   task automatic t_pll();
      cyc(4);
      rd(`EAS_ADDR_STATUS, 24'h00_0000);
      pwr = 1'b1;
      rd(`EAS_ADDR_STATUS, 24'h00_0100);
      lock = 1'b1;
      rd(`EAS_ADDR_STATUS, 24'h00_0100);
      rd(`EAS_ADDR_STATUS, 24'h00_0000);
      $display("test pll done");
   endtask : t_pll

   // mid-run reset must drop held flags, enables and the interrupt
   task automatic t_rerst();
      ovf = 1'b1;
      cyc(1);
      ovf = 1'b0;
      wr(`EAS_ADDR_INT_EN, 24'h40_0000);
      cyc(2);
      chk({23'h00_0000, int_n}, 24'h00_0000);
      rst = 1'b1;
      cyc(2);
      chk({21'h00_0000, int_n, sdo_oe, sdo}, 24'h00_0004);
      rst = 1'b0;
      cyc(3);
      rd(`EAS_ADDR_STATUS, 24'h00_0000);
      rd(`EAS_ADDR_INT_EN, 24'h00_0000);
      chk({23'h00_0000, int_n}, 24'h00_0001);
      $display("test rerst done");
   endtask : t_rerst

   // ==========
   initial
   begin
      repeat (60000) @(posedge clock);
      bad_count++;
      stop_test();
   end

   initial
   begin
      {rst, thr, ovf, frst, sync, fast, fmode, pwr, lock} = 9'h1_00;
      loff = 4'h0;
      bad_count = 0;
      compares = 0;
      cyc(5);
      rst = 1'b0;
      cyc(3);
      t_reset();
      t_noop();
      t_int();
      t_ovf();
      t_fast();
      t_loff();
      t_pll();
      t_rerst();
      stop_test();
   end
endmodule : eas_status_regs_test
